// file: dpw_pkg.sv
// Purpose: shared constants and types for the quad wiper control block
// Assumes: 20 MHz ref_clk
// Notes: command codes are the instruction byte's upper nibble
package dpw_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int NUM_WIPERS = 4;
    localparam int BITS_WIDE = 8;
    localparam int BITS_NARROW = 6;
    localparam int RESTORE_ALL_US = 1000;
    localparam int RESTORE_ONE_US = 100;
    localparam int SAVE_MS = 20;
    localparam int RESTORE_ALL_CYC = RESTORE_ALL_US * (CLK_HZ / 1000000);
    localparam int RESTORE_ONE_CYC = RESTORE_ONE_US * (CLK_HZ / 1000000);
    localparam int SAVE_CYC = SAVE_MS * (CLK_HZ / 1000);
    localparam logic [7:0] NV_RESET_VAL = 8'h80;
    localparam logic [7:0] DEV_ADDR_HI = 8'h58;
    localparam logic [3:0] CMD_WRITE = 4'h0;
    localparam logic [3:0] CMD_SAVE_A = 4'h2;
    localparam logic [3:0] CMD_SAVE_B = 4'h3;
    localparam logic [3:0] CMD_RESTORE_ALL = 4'h8;
    localparam logic [3:0] CMD_RESTORE_A = 4'h9;
    localparam logic [3:0] CMD_RESTORE_B = 4'ha;
    localparam logic [3:0] CMD_DEC = 4'h4;
    localparam logic [3:0] CMD_INC = 4'h5;
    localparam logic [3:0] CMD_SHL = 4'h6;
    localparam logic [3:0] CMD_SHR = 4'h7;

    typedef struct packed {
        logic [3:0] code;
        logic [1:0] chan;
        logic [7:0] data;
    } dpw_cmd_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BUSY = 4'b0010,
        ST_SAVE = 4'b0100,
        ST_LOAD = 4'b1000
    } dpw_state_e;
endpackage : dpw_pkg

// file: dpw_i2c_slave.sv
// Purpose: two-wire slave front end: address, instruction, data, read back
// Assumes: pins already synchronised; one command per frame
// Notes: writes fire a one-cycle cmd_valid at the frame's stop
`timescale 1ns/1ps
module dpw_i2c_slave
    import dpw_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // synchronised pins
    input wire logic scl_s,
    input wire logic sda_s,
    input wire logic [1:0] addr_pins,
    output logic sda_oe,
    // command side
    input wire logic locked,
    input wire logic [7:0] rd_data,
    output logic [1:0] rd_chan,
    output logic cmd_valid,
    output dpw_cmd_s cmd
);
    logic scl_q, sda_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [7:0] sh_q;
    logic ack_q, act_q, rd_q, done_q;
    logic [7:0] ins_q, dat_q;
    logic rise, fall, start, stop;

    assign rise = scl_s && !scl_q;
    assign fall = !scl_s && scl_q;
    assign start = scl_s && scl_q && sda_q && !sda_s;
    assign stop = scl_s && scl_q && !sda_q && sda_s;
    assign rd_chan = ins_q[1:0];

    always_ff @(posedge ref_clk)
    begin
        scl_q <= scl_s;
        sda_q <= sda_s;
    end

    always_ff @(posedge ref_clk)
    begin
        cmd_valid <= 1'b0;
        if (!reset_n || start)
        begin
            act_q <= start;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            ack_q <= 1'b0;
            rd_q <= 1'b0;
            done_q <= 1'b0;
            sda_oe <= 1'b0;
            if (!reset_n)
            begin
                ins_q <= 8'h00;
                dat_q <= 8'h00;
                sh_q <= 8'h00;
            end
        end
        else if (stop)
        begin
            // write committed only at stop, and only if not locked
            cmd_valid <= act_q && !rd_q && done_q && !locked;
            act_q <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (act_q && rise && !ack_q)
        begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
        end
        else if (act_q && rise && ack_q && rd_q && sda_s)
            act_q <= 1'b0; // master nack ends read
        else if (act_q && fall)
        begin
            if (bit_q == 4'h8)
            begin
                bit_q <= 4'h0;
                ack_q <= 1'b1;
                sda_oe <= 1'b0;
                if (byte_q == 2'h0)
                begin
                    if (sh_q[7:3] == DEV_ADDR_HI[7:3] && sh_q[2:1] == addr_pins)
                    begin
                        rd_q <= sh_q[0];
                        sda_oe <= 1'b1;
                    end
                    else
                        act_q <= 1'b0;
                end
                else if (!rd_q)
                begin
                    sda_oe <= !locked;
                    if (byte_q == 2'h1)
                        ins_q <= sh_q;
                    else
                    begin
                        dat_q <= sh_q;
                        done_q <= 1'b1;
                    end
                end
                if (byte_q != 2'h3)
                    byte_q <= byte_q + 2'h1;
            end
            else if (ack_q)
            begin
                ack_q <= 1'b0;
                if (rd_q)
                begin
                    sh_q <= rd_data;
                    sda_oe <= !rd_data[7];
                end
                else
                    sda_oe <= 1'b0;
            end
            else if (rd_q)
                // each rise shifts, so the next bit to send sits at the top
                sda_oe <= !sh_q[7];
        end
    end

    always_comb
    begin
        cmd.code = ins_q[7:4];
        cmd.chan = ins_q[1:0];
        cmd.data = dat_q;
    end
endmodule : dpw_i2c_slave

// file: dpw_wiper_ctrl.sv
// Summary of operation
// - a write command loads any position into the chosen wiper setting
// - restore command copies the stored value back into the wiper setting
// - save command copies a wiper setting into its nonvolatile store slot
// - at power-up every wiper setting loads from its store slot
// - the power-up transfer finishes just over one millisecond after reset
// - increment and decrement move one wiper by one position, holding at either end
// - shift commands adjust all four wipers at once in about 6dB steps
// - four independent wipers of 64 or 256 positions
// - the master can read back the current wiper settings
// - save commands 2 and 3 finish within 25 ms
// - ready is low only in reset, during the power-up and preset restores, and during commands 8, 9, 10, 2, 3
// - an external preset pin triggers the same restore of all wipers
// - direction bit high means read, low means write
// - on the 64-position part the top two data bits are ignored
// - while the store updates, serial input is locked
//
// Purpose: control core of a quad digital potentiometer
// Assumes: scl, sda, preset pin asynchronous; nonvolatile store modelled as flops
// Notes: store holds its contents across reset_n; power-up preset runs after reset
`timescale 1ns/1ps
module dpw_wiper_ctrl
    import dpw_pkg::*;
#(
    parameter int WIDTH = BITS_WIDE,
    parameter int SAVE_CYCLES = SAVE_CYC,
    parameter int LOAD_ALL_CYCLES = RESTORE_ALL_CYC,
    parameter int LOAD_ONE_CYCLES = RESTORE_ONE_CYC
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // two-wire bus
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_pins,
    // preset and status
    input wire logic preset_n,
    output logic ready,
    // wiper positions
    output logic [4*WIDTH-1:0] wiper_pos
);
    localparam logic [WIDTH-1:0] FULL = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] RST_VAL = WIDTH'(NV_RESET_VAL >> (BITS_WIDE - WIDTH));

    logic [1:0] scl_sy, sda_sy, pre_sy, adr_sy0, adr_sy1;
    logic [WIDTH-1:0] wiper_q [NUM_WIPERS];
    logic [WIDTH-1:0] nv_q [NUM_WIPERS];
    // power-on value only: reset_n must leave the store alone
    logic nv_init_q = 1'b0;
    dpw_state_e state_q;
    logic [31:0] cnt_q;
    logic [3:0] op_q;
    logic [1:0] op_ch_q;
    logic pre_d1_q, boot_q;
    logic cmd_valid, oe_int;
    logic [1:0] rd_chan;
    dpw_cmd_s cmd;

    function automatic logic [WIDTH-1:0] fit(input logic [7:0] v);
        fit = v[WIDTH-1:0];
    endfunction : fit

    // two-stage synchronisers, only the second stage feeds logic
    always_ff @(posedge ref_clk)
    begin
        scl_sy <= {scl_sy[0], scl};
        sda_sy <= {sda_sy[0], sda_in};
        pre_sy <= {pre_sy[0], preset_n};
        adr_sy0 <= addr_pins;
        adr_sy1 <= adr_sy0;
    end

    dpw_i2c_slave u_slave (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .scl_s(scl_sy[1]),
        .sda_s(sda_sy[1]),
        .addr_pins(adr_sy1),
        .sda_oe(oe_int),
        .locked(state_q == ST_SAVE),
        .rd_data(8'(wiper_q[rd_chan])),
        .rd_chan(rd_chan),
        .cmd_valid(cmd_valid),
        .cmd(cmd)
    );

    always_ff @(posedge ref_clk)
    begin
        sda_oe <= oe_int;
        sda_out <= 1'b0;
        pre_d1_q <= pre_sy[1];
    end

    // sequencer for timed commands
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0;
            op_q <= CMD_RESTORE_ALL;
            op_ch_q <= 2'h0;
            boot_q <= 1'b1;
            ready <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    ready <= 1'b1;
                    if (boot_q || (pre_d1_q && !pre_sy[1]))
                    begin
                        boot_q <= 1'b0;
                        op_q <= CMD_RESTORE_ALL;
                        cnt_q <= 32'(LOAD_ALL_CYCLES - 1);
                        state_q <= ST_BUSY;
                        ready <= 1'b0;
                    end
                    else if (cmd_valid)
                    begin
                        op_q <= cmd.code;
                        op_ch_q <= cmd.chan;
                        if (cmd.code == CMD_SAVE_A || cmd.code == CMD_SAVE_B)
                        begin
                            cnt_q <= 32'(SAVE_CYCLES - 1);
                            state_q <= ST_SAVE;
                            ready <= 1'b0;
                        end
                        else if (cmd.code == CMD_RESTORE_ALL)
                        begin
                            cnt_q <= 32'(LOAD_ALL_CYCLES - 1);
                            state_q <= ST_BUSY;
                            ready <= 1'b0;
                        end
                        else if (cmd.code == CMD_RESTORE_A || cmd.code == CMD_RESTORE_B)
                        begin
                            cnt_q <= 32'(LOAD_ONE_CYCLES - 1);
                            state_q <= ST_BUSY;
                            ready <= 1'b0;
                        end
                    end
                end
                ST_BUSY, ST_SAVE:
                begin
                    if (cnt_q == 32'h0)
                        state_q <= ST_LOAD;
                    else
                        cnt_q <= cnt_q - 32'h1;
                end
                ST_LOAD:
                begin
                    state_q <= ST_IDLE;
                    ready <= 1'b1;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // nonvolatile store, survives reset_n; first use after config sets factory value
    always_ff @(posedge ref_clk)
    begin
        if (!nv_init_q)
        begin
            nv_init_q <= 1'b1;
            for (int i = 0; i < NUM_WIPERS; i++)
                nv_q[i] <= RST_VAL;
        end
        else if (state_q == ST_LOAD && (op_q == CMD_SAVE_A || op_q == CMD_SAVE_B))
            nv_q[op_ch_q] <= wiper_q[op_ch_q];
    end

    // wiper setting registers
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < NUM_WIPERS; i++)
                wiper_q[i] <= RST_VAL;
        end
        else if (state_q == ST_LOAD && op_q == CMD_RESTORE_ALL)
        begin
            for (int i = 0; i < NUM_WIPERS; i++)
                wiper_q[i] <= nv_q[i];
        end
        else if (state_q == ST_LOAD && (op_q == CMD_RESTORE_A || op_q == CMD_RESTORE_B))
            wiper_q[op_ch_q] <= nv_q[op_ch_q];
        else if (state_q == ST_IDLE && cmd_valid && !boot_q)
        begin
            case (cmd.code)
                CMD_WRITE:
                    wiper_q[cmd.chan] <= fit(cmd.data);
                CMD_INC:
                    if (wiper_q[cmd.chan] != FULL)
                        wiper_q[cmd.chan] <= wiper_q[cmd.chan] + 1'b1;
                CMD_DEC:
                    if (wiper_q[cmd.chan] != '0)
                        wiper_q[cmd.chan] <= wiper_q[cmd.chan] - 1'b1;
                CMD_SHL:
                    for (int i = 0; i < NUM_WIPERS; i++)
                        wiper_q[i] <= wiper_q[i][WIDTH-1] ? FULL : {wiper_q[i][WIDTH-2:0], 1'b0};
                CMD_SHR:
                    for (int i = 0; i < NUM_WIPERS; i++)
                        wiper_q[i] <= wiper_q[i] >> 1;
                default:
                    ;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < NUM_WIPERS; i++)
            wiper_pos[i*WIDTH +: WIDTH] <= wiper_q[i];
    end

    // assertions
    property p_ready_low;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_BUSY || state_q == ST_SAVE) |-> !ready;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready high while busy");
    property p_save_len;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_SAVE) |-> (cnt_q < 32'(SAVE_CYCLES));
    endproperty
    a_save_len: assert property (p_save_len) else $error("save too long");
    property p_lock;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_SAVE) |-> !cmd_valid;
    endproperty
    a_lock: assert property (p_lock) else $error("command during save");
    property p_sat;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_IDLE && cmd_valid && !boot_q && cmd.code == CMD_INC
         && wiper_q[cmd.chan] == FULL) |=> wiper_q[$past(cmd.chan)] == FULL;
    endproperty
    a_sat: assert property (p_sat) else $error("increment wrapped");
    property p_boot;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(reset_n) |-> ##[1:3] (state_q == ST_BUSY);
    endproperty
    a_boot: assert property (p_boot) else $error("no power-up restore");
    property p_ready_back;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_LOAD) |=> ready;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not restored");
    property p_restore;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_LOAD && op_q == CMD_RESTORE_ALL) |=> wiper_q[0] == $past(nv_q[0]);
    endproperty
    a_restore: assert property (p_restore) else $error("restore mismatch");
    property p_write;
        @(posedge ref_clk) disable iff (!reset_n)
        (state_q == ST_IDLE && cmd_valid && !boot_q && cmd.code == CMD_WRITE && cmd.chan == 2'h0)
        |=> wiper_q[0] == fit($past(cmd.data));
    endproperty
    a_write: assert property (p_write) else $error("write not taken");
    c_save: cover property (@(posedge ref_clk) $rose(state_q == ST_SAVE));
    c_write: cover property (@(posedge ref_clk) cmd_valid && cmd.code == CMD_WRITE);
    c_preset: cover property (@(posedge ref_clk) pre_d1_q && !pre_sy[1]);
endmodule : dpw_wiper_ctrl

// file: dpw_i2c_bfm.sv
// Purpose: behavioural two-wire bus master for the wiper block
// Assumes: sda has a pull-up, so a released line reads high
// Notes: one bit takes three waits of Q ref_clk cycles each
`timescale 1ns/1ps
module dpw_i2c_bfm
#(
    parameter int Q = 8
)
(
    // clock
    input wire logic ref_clk,
    // bus
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic qw;
        repeat (Q) @(posedge ref_clk);
        #1;
    endtask : qw

    // sda only moves while scl is low; sampled at scl high
    task automatic bit_x(input logic b, output logic s);
        sda_low = !b;
        qw();
        scl = 1'b1;
        qw();
        s = sda;
        scl = 1'b0;
        qw();
    endtask : bit_x

    // master releases the ack slot, so a read ends with a nack
    task automatic byte_x(input logic [7:0] b, output logic [7:0] s, output logic nak);
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], s[i]);
        bit_x(1'b1, nak);
    endtask : byte_x

    task automatic xfer(input logic [7:0] adr, input logic [7:0] ins, input logic [7:0] dat,
        input int n, output logic [7:0] rd, output logic [2:0] nak);
        nak = 3'b000;
        sda_low = 1'b1;
        qw();
        scl = 1'b0;
        qw();
        byte_x(adr, rd, nak[2]);
        if (n > 1)
            byte_x(ins, rd, nak[1]);
        if (n > 2)
            byte_x(dat, rd, nak[0]);
        sda_low = 1'b1;
        qw();
        scl = 1'b1;
        qw();
        sda_low = 1'b0;
        qw();
    endtask : xfer
endmodule : dpw_i2c_bfm

// file: tb_top.sv
// Purpose: self-checking bench for the quad wiper control block
// Assumes: wide and narrow parts share one bus at different straps
// Notes: long counts shortened by parameters; save kept longer than a frame
`timescale 1ns/1ps
module tb_top
    import dpw_pkg::*;
;
    localparam int SV = 4000;
    localparam int LA = 20;
    localparam int LO = 10;
    localparam logic [7:0] A8 = 8'h5c;
    localparam logic [7:0] A6 = 8'h5a;
    logic ref_clk, reset_n, preset_n, scl, m_low, oe8, oe6, rdy8, rdy6, low_seen, so8;
    logic [31:0] pos8;
    logic [23:0] pos6;
    logic [7:0] rd;
    logic [2:0] nak;
    wire logic sda;
    int err_count;
    int comparisons;

    assign sda = !(m_low | oe8 | oe6);

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
        if (rdy8 !== 1'b1)
            low_seen <= 1'b1;

    dpw_wiper_ctrl #(.WIDTH(8), .SAVE_CYCLES(SV), .LOAD_ALL_CYCLES(LA),
        .LOAD_ONE_CYCLES(LO)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .scl(scl),
        .sda_in(sda), .sda_out(so8), .sda_oe(oe8), .addr_pins(2'b10), .preset_n(preset_n),
        .ready(rdy8), .wiper_pos(pos8));
    dpw_wiper_ctrl #(.WIDTH(6), .SAVE_CYCLES(SV), .LOAD_ALL_CYCLES(LA),
        .LOAD_ONE_CYCLES(LO)) dut6 (.ref_clk(ref_clk), .reset_n(reset_n), .scl(scl),
        .sda_in(sda), .sda_out(), .sda_oe(oe6), .addr_pins(2'b01), .preset_n(preset_n),
        .ready(rdy6), .wiper_pos(pos6));
    dpw_i2c_bfm #(.Q(8)) m (.ref_clk(ref_clk), .scl(scl), .sda_low(m_low), .sda(sda));

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk

    // bounded wait: running out ends the run
    task automatic wait_rdy(input int bound);
        int n;
        n = 0;
        while (rdy8 !== 1'b1 || rdy6 !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > bound)
            begin
                $display("ERROR ready expected 1 seen %b", rdy8);
                err_count++;
                stop_test();
            end
        end
        // wiper_pos trails the internal register by one cycle
        @(posedge ref_clk);
        #1;
    endtask : wait_rdy

    task automatic wr(input logic [7:0] adr, input logic [3:0] code, input logic [1:0] ch,
        input logic [7:0] dat);
        m.xfer(adr, {code, 2'b00, ch}, dat, 3, rd, nak);
    endtask : wr

    task automatic op(input logic [3:0] code, input logic [1:0] ch, input logic [7:0] dat,
        input logic [7:0] exp);
        wr(A8, code, ch, dat);
        chk("ack", 32'h0, {29'h0, nak});
        chk("wiper", {24'h0, exp}, {24'h0, pos8[{ch, 3'b000} +: 8]});
    endtask : op

    task automatic t_power(input logic [31:0] exp);
        chk("ready in reset", 32'h0, {31'h0, rdy8});
        chk("sda out", 32'h0, {31'h0, so8});
        wait_rdy(LA + 20);
        chk("preset wide", exp, pos8);
        chk("preset narrow", {8'h0, {4{6'h20}}}, {8'h0, pos6});
        $display("test power done");
    endtask : t_power

    task automatic t_write;
        low_seen = 1'b0;
        for (int i = 0; i < 4; i++)
            op(CMD_WRITE, i[1:0], 8'(17 * (i + 1)), 8'(17 * (i + 1)));
        chk("ready kept", 32'h0, {31'h0, low_seen});
        m.xfer(A8 | 8'h01, 8'hff, 8'h00, 2, rd, nak);
        chk("read back", 32'h44, {24'h0, rd});
        wr(8'h5e, CMD_WRITE, 2'd0, 8'h00);
        chk("foreign nack", 32'h7, {29'h0, nak});
        chk("untouched", 32'h44332211, pos8);
        wr(A6, CMD_WRITE, 2'd3, 8'hc5);
        chk("narrow data", 32'h05, {26'h0, pos6[23:18]});
        $display("test write done");
    endtask : t_write

    task automatic t_step;
        op(CMD_WRITE, 2'd1, 8'hff, 8'hff);
        op(CMD_INC, 2'd1, 8'h00, 8'hff);
        op(CMD_DEC, 2'd1, 8'h00, 8'hfe);
        op(CMD_WRITE, 2'd1, 8'h00, 8'h00);
        op(CMD_DEC, 2'd1, 8'h00, 8'h00);
        op(CMD_INC, 2'd1, 8'h00, 8'h01);
        op(CMD_WRITE, 2'd0, 8'h50, 8'h50);
        op(CMD_WRITE, 2'd3, 8'h90, 8'h90);
        op(CMD_SHL, 2'd0, 8'h00, 8'ha0);
        chk("shl clamp", 32'hff, {24'h0, pos8[31:24]});
        op(CMD_SHR, 2'd0, 8'h00, 8'h50);
        chk("shr all", 32'h7f, {24'h0, pos8[31:24]});
        $display("test step done");
    endtask : t_step

    task automatic t_store;
        for (int i = 0; i < 2; i++)
        begin
            op(CMD_WRITE, i[1:0], 8'(51 + i), 8'(51 + i));
            low_seen = 1'b0;
            wr(A8, i ? CMD_SAVE_B : CMD_SAVE_A, i[1:0], 8'h00);
            wr(A8, CMD_WRITE, i[1:0], 8'h00);
            chk("locked nack", 32'h1, {31'h0, nak[0]});
            wait_rdy(SV + 20);
            chk("save busy", 32'h1, {31'h0, low_seen});
            chk("locked keep", 32'(51 + i), {24'h0, pos8[8 * i +: 8]});
            op(CMD_WRITE, i[1:0], 8'h44, 8'h44);
            low_seen = 1'b0;
            wr(A8, i ? CMD_RESTORE_B : CMD_RESTORE_A, i[1:0], 8'h00);
            wait_rdy(LO + 20);
            chk("restore busy", 32'h1, {31'h0, low_seen});
            chk("restore one", 32'(51 + i), {24'h0, pos8[8 * i +: 8]});
        end
        op(CMD_WRITE, 2'd0, 8'h00, 8'h00);
        op(CMD_WRITE, 2'd1, 8'h00, 8'h00);
        low_seen = 1'b0;
        wr(A8, CMD_RESTORE_ALL, 2'd0, 8'h00);
        wait_rdy(LA + 20);
        chk("restore all busy", 32'h1, {31'h0, low_seen});
        chk("restore all", 32'h3433, {16'h0, pos8[15:0]});
        $display("test store done");
    endtask : t_store

    task automatic t_preset;
        op(CMD_WRITE, 2'd0, 8'h5a, 8'h5a);
        low_seen = 1'b0;
        preset_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        preset_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        wait_rdy(LA + 20);
        chk("preset busy", 32'h1, {31'h0, low_seen});
        chk("preset load", 32'h33, {24'h0, pos8[7:0]});
        reset_n = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        t_power(32'h80803433);
        $display("test preset done");
    endtask : t_preset

    initial
    begin
        err_count = 0;
        comparisons = 0;
        low_seen = 1'b0;
        reset_n = 1'b0;
        preset_n = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        t_power(32'h80808080);
        t_write();
        t_step();
        t_store();
        t_preset();
        stop_test();
    end
endmodule : tb_top
